/* verilog/lhr_header_rx.sv */
`timescale 1ns/1ps
module lhr_header_rx
	import lhr_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Register port
	input lhr_pkg::lhr_bus_req_t bus_req,
	output logic [7:0] rdata_reg,
	// Line
	input wire logic rx_pin,
	// Interrupt request
	output logic irq
);
	import lhr_pkg::*;

	typedef enum logic [1:0] {LHR_WAIT_BRK, LHR_WAIT_SYNC, LHR_WAIT_ID}
		lhr_hdr_t;

	function automatic logic id_parity_ok(input logic [7:0] id);
		id_parity_ok = (id[6] == (id[0] ^ id[1] ^ id[2] ^ id[4])) &&
			(id[7] == ~(id[1] ^ id[3] ^ id[4] ^ id[5]));
	endfunction : id_parity_ok

	logic [7:0] data_reg, ctrl2_reg, ctrl3_reg, ctrl6_reg;
	logic [15:0] div_reg;
	logic receive_not_empty_flag_reg, fe_reg, he_reg, sr_seen_reg;
	logic hdf_reg, pe_reg, lsf_reg, brk_reg;
	lhr_hdr_t hdr_reg;
	logic [5:0] tout_reg;
	logic tout_run_reg;
	logic rx_meta_reg, rx_sync_reg;
	logic [15:0] baud_cnt_reg;
	logic tick16;
	lhr_char_t ch;
	logic ch_valid, bit_tick;

	logic lin_slave, mute, wr_c6, rd_data;
	assign lin_slave = ctrl3_reg[LHR_C3_BUS_MODE_ENABLE] & ctrl6_reg[LHR_C6_SLV];
	assign mute = ctrl2_reg[LHR_C2_RWU];
	assign wr_c6 = bus_req.wr && bus_req.addr == LHR_OFF_CTRL6;
	assign rd_data = bus_req.rd && bus_req.addr == LHR_OFF_DATA;

	// Pin passes two flops before any logic
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			rx_meta_reg <= 1'b1;
			rx_sync_reg <= 1'b1;
		end
		else
		begin
			rx_meta_reg <= rx_pin;
			rx_sync_reg <= rx_meta_reg;
		end
	end

	// Oversampling enable at 16x the bit rate
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			baud_cnt_reg <= 16'h0000;
		else if (tick16)
			baud_cnt_reg <= 16'h0000;
		else
			baud_cnt_reg <= baud_cnt_reg + 16'h0001;
	end
	assign tick16 = baud_cnt_reg >= (div_reg >> 4);

	lhr_char_rx u_char_rx (
		.sys_clk(sys_clk),
		.rst(rst),
		.tick16(tick16),
		.enable(ctrl2_reg[LHR_C2_REN]),
		.rx_sync(rx_sync_reg),
		.char_reg(ch),
		.char_valid_reg(ch_valid),
		.bit_tick_reg(bit_tick)
	);

	// Header sequencing events
	logic ev_break, ev_sync, ev_id, ev_sync_err, ev_id_err, ev_tout;
	logic ev_data, lsf_fall;
	assign ev_break = ch_valid && ch.is_break && lin_slave;
	assign ev_sync = ch_valid && !ch.is_break && hdr_reg == LHR_WAIT_SYNC;
	assign ev_id = ch_valid && !ch.is_break && hdr_reg == LHR_WAIT_ID;
	assign ev_sync_err = ev_sync &&
		(ch.frame_err || ch.data != LHR_SYNC_BYTE);
	assign ev_id_err = ev_id && ch.frame_err;
	assign ev_tout = tout_run_reg && bit_tick &&
		tout_reg == LHR_HEADER_LIMIT;
	assign ev_data = ch_valid && !ch.is_break && !ev_sync && !ev_id;
	assign lsf_fall = wr_c6 && lsf_reg && !bus_req.wdata[LHR_C6_LSF];

	// Header state: break, sync, then identifier as third character
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			hdr_reg <= LHR_WAIT_BRK;
		else if (ev_break)
			hdr_reg <= LHR_WAIT_SYNC;
		else if (ev_tout && hdr_reg == LHR_WAIT_SYNC &&
			ctrl6_reg[LHR_C6_ASE])
			hdr_reg <= LHR_WAIT_SYNC;
		else if (ev_tout || ev_sync_err || ev_id || lsf_fall)
			hdr_reg <= LHR_WAIT_BRK;
		else if (ev_sync)
			hdr_reg <= LHR_WAIT_ID;
	end

	// Header time-out counter in local bit periods
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			tout_reg <= 6'd0;
			tout_run_reg <= 1'b0;
		end
		else if (ev_break)
		begin
			tout_reg <= 6'd0;
			tout_run_reg <= 1'b1;
		end
		else if (ev_id || ev_sync_err || ev_tout ||
			(lsf_fall && hdr_reg == LHR_WAIT_SYNC))
			tout_run_reg <= 1'b0;
		else if (tout_run_reg && bit_tick)
			tout_reg <= tout_reg + 6'd1;
	end

	// Analysis flag: set on break, held after a blocked time-out
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			lsf_reg <= 1'b0;
		else if (ev_break)
			lsf_reg <= 1'b1;
		else if (wr_c6)
			lsf_reg <= bus_req.wdata[LHR_C6_LSF];
	end

	// Header error: set wins over the status-then-data clear
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			he_reg <= 1'b0;
			sr_seen_reg <= 1'b0;
		end
		else
		begin
			if (bus_req.rd || bus_req.wr)
				sr_seen_reg <= bus_req.addr == LHR_OFF_STATUS;
			if (ev_sync_err || ev_id_err || ev_tout)
				he_reg <= 1'b1;
			else if (rd_data && sr_seen_reg)
				he_reg <= 1'b0;
		end
	end

	// Header detected, parity error and mute wake-up
	logic wake;
	assign wake = ev_id && !ev_id_err && !ev_tout;
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			hdf_reg <= 1'b0;
			pe_reg <= 1'b0;
		end
		else
		begin
			if (wake)
			begin
				hdf_reg <= 1'b1;
				if (ctrl2_reg[LHR_C2_PARITY_CHECK_ENABLE] && !id_parity_ok(ch.data))
					pe_reg <= 1'b1;
			end
			else if (wr_c6)
			begin
				hdf_reg <= hdf_reg & bus_req.wdata[LHR_C6_HDF];
				pe_reg <= pe_reg & bus_req.wdata[LHR_C6_PE];
			end
		end
	end

	// Data, receive-not-empty, framing error, master break flag
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			data_reg <= LHR_RST_BYTE;
			receive_not_empty_flag_reg <= 1'b0;
			fe_reg <= 1'b0;
			brk_reg <= 1'b0;
		end
		else
		begin
			if (wake || (ev_data && !mute))
			begin
				data_reg <= ch.data;
				receive_not_empty_flag_reg <= 1'b1;
				fe_reg <= ch.frame_err;
			end
			else if (ch_valid && ch.is_break && !lin_slave)
			begin
				receive_not_empty_flag_reg <= 1'b1;
				fe_reg <= 1'b1;
			end
			else if (rd_data)
				receive_not_empty_flag_reg <= 1'b0;
			if (ev_data && mute)
				fe_reg <= fe_reg;
			// Break flag is set at the first bit tick after an unread framing-error character (break or data) that finds the line high again
			if (bit_tick && receive_not_empty_flag_reg && fe_reg && !lin_slave &&
				ctrl3_reg[LHR_C3_BUS_MODE_ENABLE] && rx_sync_reg)
				brk_reg <= 1'b1;
			else if (wr_c6)
				brk_reg <= 1'b0;
		end
	end

	// Mute bit is cleared by hardware on wake-up
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl2_reg <= LHR_RST_BYTE;
			ctrl3_reg <= LHR_RST_BYTE;
			ctrl6_reg <= LHR_RST_BYTE;
			div_reg <= LHR_RST_DIV;
		end
		else
		begin
			if (bus_req.wr && bus_req.addr == LHR_OFF_CTRL2)
				ctrl2_reg <= bus_req.wdata;
			else if (wake)
				ctrl2_reg[LHR_C2_RWU] <= 1'b0;
			if (bus_req.wr && bus_req.addr == LHR_OFF_CTRL3)
				ctrl3_reg <= bus_req.wdata;
			if (wr_c6)
				ctrl6_reg <= bus_req.wdata;
			if (bus_req.wr && bus_req.addr == LHR_OFF_BAUD_LO)
				div_reg[7:0] <= bus_req.wdata;
			if (bus_req.wr && bus_req.addr == LHR_OFF_BAUD_HI)
				div_reg[15:8] <= bus_req.wdata;
		end
	end

	// Read data, valid in the cycle after the strobe
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			rdata_reg <= 8'h00;
		else if (!bus_req.rd)
			rdata_reg <= 8'h00;
		else if (bus_req.addr == LHR_OFF_DATA)
			rdata_reg <= data_reg;
		else if (bus_req.addr == LHR_OFF_STATUS)
			rdata_reg <= {2'b00, receive_not_empty_flag_reg, 1'b0, he_reg, 1'b0,
				fe_reg, 1'b0};
		else if (bus_req.addr == LHR_OFF_CTRL2)
			rdata_reg <= ctrl2_reg;
		else if (bus_req.addr == LHR_OFF_CTRL3)
			rdata_reg <= ctrl3_reg;
		else if (bus_req.addr == LHR_OFF_CTRL6)
			rdata_reg <= {brk_reg, ctrl6_reg[6:5], lsf_reg,
				ctrl6_reg[3], pe_reg, ctrl6_reg[1], hdf_reg};
		else if (bus_req.addr == LHR_OFF_BAUD_LO)
			rdata_reg <= div_reg[7:0];
		else if (bus_req.addr == LHR_OFF_BAUD_HI)
			rdata_reg <= div_reg[15:8];
		else
			rdata_reg <= 8'h00;
	end

	assign irq = (hdf_reg && ctrl6_reg[LHR_C6_HDIEN]) ||
		(pe_reg && ctrl6_reg[LHR_C6_PARITY_INTERRUPT_ENABLE]) ||
		((he_reg || receive_not_empty_flag_reg) && ctrl2_reg[LHR_C2_RECEIVE_INTERRUPT_ENABLE]);

	property p_he_irq;
		@(posedge sys_clk) disable iff (rst)
		(he_reg && ctrl2_reg[LHR_C2_RECEIVE_INTERRUPT_ENABLE]) |-> irq;
	endproperty
	a_he_irq: assert property (p_he_irq) else $error("no irq on header error");

	property p_tout_sets_he;
		@(posedge sys_clk) disable iff (rst)
		ev_tout |=> he_reg;
	endproperty
	a_tout_sets_he: assert property (p_tout_sets_he) else $error("timeout lost");

	property p_no_early_tout;
		@(posedge sys_clk) disable iff (rst)
		ev_tout |-> tout_reg == 6'd57;
	endproperty
	a_no_early_tout: assert property (p_no_early_tout) else $error("early timeout");

	property p_break_resets;
		@(posedge sys_clk) disable iff (rst)
		ev_break |=> tout_reg == 6'd0 && tout_run_reg;
	endproperty
	a_break_resets: assert property (p_break_resets) else $error("counter not cleared");

	property p_wake_hdf;
		@(posedge sys_clk) disable iff (rst)
		wake |=> hdf_reg && data_reg == $past(ch.data) && !mute;
	endproperty
	a_wake_hdf: assert property (p_wake_hdf) else $error("header not flagged");

	property p_parity;
		@(posedge sys_clk) disable iff (rst)
		(wake && ctrl2_reg[LHR_C2_PARITY_CHECK_ENABLE] && !id_parity_ok(ch.data)) |=> pe_reg && hdf_reg;
	endproperty
	a_parity: assert property (p_parity) else $error("parity error missed");

	property p_mute_drop;
		@(posedge sys_clk) disable iff (rst)
		(ev_data && mute && !receive_not_empty_flag_reg) |=> !receive_not_empty_flag_reg;
	endproperty
	a_mute_drop: assert property (p_mute_drop) else $error("mute delivered data");

	property p_mute_fe;
		@(posedge sys_clk) disable iff (rst)
		(ev_data && mute && !fe_reg) |=> !fe_reg;
	endproperty
	a_mute_fe: assert property (p_mute_fe) else $error("mute framing flag set");

	property p_err_no_wake;
		@(posedge sys_clk) disable iff (rst)
		(ev_sync_err && mute) |=> mute && hdr_reg == LHR_WAIT_BRK;
	endproperty
	a_err_no_wake: assert property (p_err_no_wake) else $error("woke on error");

	c_header: cover property (@(posedge sys_clk) disable iff (rst) wake);
	c_tout: cover property (@(posedge sys_clk) disable iff (rst) ev_tout);
	c_sync_err: cover property (@(posedge sys_clk) disable iff (rst) ev_sync_err);

endmodule : lhr_header_rx

/* verilog/lhr_pkg.sv */
package lhr_pkg;

	// Register offsets over the plain register port
	localparam logic [3:0] LHR_OFF_DATA = 4'h0;
	localparam logic [3:0] LHR_OFF_STATUS = 4'h1;
	localparam logic [3:0] LHR_OFF_CTRL2 = 4'h2;
	localparam logic [3:0] LHR_OFF_CTRL3 = 4'h3;
	localparam logic [3:0] LHR_OFF_CTRL6 = 4'h4;
	localparam logic [3:0] LHR_OFF_BAUD_LO = 4'h5;
	localparam logic [3:0] LHR_OFF_BAUD_HI = 4'h6;

	// Status register bit positions
	localparam int LHR_SR_FE = 1;
	localparam int LHR_SR_HE = 3;
	localparam int LHR_SR_RECEIVE_NOT_EMPTY_FLAG = 5;
	// Control two
	localparam int LHR_C2_PARITY_CHECK_ENABLE = 0;
	localparam int LHR_C2_RWU = 1;
	localparam int LHR_C2_REN = 2;
	localparam int LHR_C2_TEN = 3;
	localparam int LHR_C2_RECEIVE_INTERRUPT_ENABLE = 5;
	// Control three
	localparam int LHR_C3_BUS_MODE_ENABLE = 6;
	// Control six
	localparam int LHR_C6_HDF = 0;
	localparam int LHR_C6_HDIEN = 1;
	localparam int LHR_C6_PE = 2;
	localparam int LHR_C6_PARITY_INTERRUPT_ENABLE = 3;
	localparam int LHR_C6_LSF = 4;
	localparam int LHR_C6_ASE = 5;
	localparam int LHR_C6_SLV = 6;

	// Reset values
	localparam logic [7:0] LHR_RST_BYTE = 8'h00;
	localparam logic [15:0] LHR_RST_DIV = 16'h0010;
	localparam logic [3:0] LHR_OVERSAMPLE = 4'hf;

	// Header timing, in local bit periods
	localparam logic [5:0] LHR_HEADER_LIMIT = 6'd57;
	localparam logic [7:0] LHR_SYNC_BYTE = 8'h55;
	localparam logic [3:0] LHR_BREAK_BITS = 4'd10;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} lhr_bus_req_t;

	typedef struct packed {
		logic [7:0] data;
		logic frame_err;
		logic is_break;
	} lhr_char_t;

endpackage : lhr_pkg

/* verilog/lhr_char_rx.sv */
`timescale 1ns/1ps
// Character receiver: 16x oversampling, 8N1, break recognition
module lhr_char_rx
	import lhr_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Timing
	input wire logic tick16,
	input wire logic enable,
	// Line
	input wire logic rx_sync,
	// Character out
	output lhr_pkg::lhr_char_t char_reg,
	output logic char_valid_reg,
	output logic bit_tick_reg
);
	typedef enum logic [1:0] {LHR_IDLE, LHR_START, LHR_BITS, LHR_STOP} lhr_rx_t;
	lhr_rx_t state_reg;
	logic [3:0] phase_reg;
	logic [3:0] count_reg;
	logic [7:0] shift_reg;
	logic zeros_reg;
	logic armed_reg;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= LHR_IDLE;
			phase_reg <= 4'h0;
			count_reg <= 4'h0;
			shift_reg <= 8'h00;
			zeros_reg <= 1'b0;
			armed_reg <= 1'b0;
			char_reg <= '0;
			char_valid_reg <= 1'b0;
		end
		else
		begin
			char_valid_reg <= 1'b0;
			if (!enable)
				state_reg <= LHR_IDLE;
			else if (tick16)
			begin
				phase_reg <= phase_reg + 4'h1;
				case (state_reg)
				// Only a fall from high starts a character, so the
				// low tail of a break is not taken for a start bit
				LHR_IDLE:
					if (!rx_sync && armed_reg)
					begin
						state_reg <= LHR_START;
						phase_reg <= 4'h0;
						armed_reg <= 1'b0;
					end
					else if (rx_sync)
						armed_reg <= 1'b1;
				LHR_START:
					if (phase_reg == 4'h7)
					begin
						// A glitch is not a start bit
						state_reg <= rx_sync ? LHR_IDLE : LHR_BITS;
						phase_reg <= 4'h0;
						count_reg <= 4'h0;
						zeros_reg <= 1'b1;
					end
				LHR_BITS:
					if (phase_reg == LHR_OVERSAMPLE)
					begin
						shift_reg <= {rx_sync, shift_reg[7:1]};
						zeros_reg <= zeros_reg & ~rx_sync;
						count_reg <= count_reg + 4'h1;
						if (count_reg == 4'h7)
							state_reg <= LHR_STOP;
					end
				default:
					if (phase_reg == LHR_OVERSAMPLE)
					begin
						char_reg.data <= shift_reg;
						char_reg.frame_err <= ~rx_sync;
						// Ten low bits incl. start and stop form a break
						char_reg.is_break <= zeros_reg & ~rx_sync;
						char_valid_reg <= 1'b1;
						// A low stop bit waits for the line to go high
						armed_reg <= rx_sync;
						state_reg <= LHR_IDLE;
					end
				endcase
			end
		end
	end

	logic [3:0] div16_reg;
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			div16_reg <= 4'h0;
			bit_tick_reg <= 1'b0;
		end
		else
		begin
			bit_tick_reg <= tick16 && div16_reg == LHR_OVERSAMPLE;
			if (tick16)
				div16_reg <= div16_reg + 4'h1;
		end
	end

endmodule : lhr_char_rx

/* dv/lhr_lin_master.sv */
`timescale 1ns/1ps
// Bus master node driving the slave's receive line, 8N1, LSB first
module lhr_lin_master #(
	parameter int BIT_CLKS = 32
)(
	// Clock
	input wire logic sys_clk,
	// Line, recessive high between characters as the pull-up leaves it
	output logic line
);
	initial line = 1'b1;

	task automatic hold_bits(input logic lvl, input int n);
		begin
			line <= lvl;
			repeat (n * BIT_CLKS) @(posedge sys_clk);
		end
	endtask : hold_bits

	// A low stop bit is the only way to force a framing error
	task automatic send_char(input logic [7:0] d, input logic stop);
		begin
			hold_bits(1'b0, 1);
			for (int i = 0; i < 8; i++)
				hold_bits(d[i], 1);
			hold_bits(stop, 1);
			// After a low stop bit the line idles one bit before the next start
			if (!stop)
				hold_bits(1'b1, 1);
		end
	endtask : send_char

	task automatic send_header(input logic [7:0] sync, input logic [7:0] id);
		begin
			hold_bits(1'b0, 13);
			hold_bits(1'b1, 1);
			send_char(sync, 1'b1);
			send_char(id, 1'b1);
		end
	endtask : send_header
endmodule : lhr_lin_master

/* dv/lin_header_and_response_logic_test.sv */
`timescale 1ns/1ps
module lin_header_and_response_logic_test;
	import lhr_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	lhr_bus_req_t bus_req = '0;
	logic [7:0] rdata_reg;
	logic rx_pin;
	logic irq;
	int failures = 0;
	int checks_done = 0;
	int cycles = 0;
	// Parity check, receiver, transmitter and rx interrupt enabled
	localparam logic [7:0] C2_RUN = 8'h2d;
	// Slave role, header and parity interrupt enables
	localparam logic [7:0] C6_RUN = 8'h4a;

	always #4 sys_clk = ~sys_clk;

	lhr_header_rx uut (
		.sys_clk(sys_clk),
		.rst(rst),
		.bus_req(bus_req),
		.rdata_reg(rdata_reg),
		.rx_pin(rx_pin),
		.irq(irq)
	);

	// Divider 0x0010 gives a tick every 2 clocks, 16 ticks a bit
	lhr_lin_master #(.BIT_CLKS(32)) master (
		.sys_clk(sys_clk),
		.line(rx_pin)
	);

	task automatic finish_test;
		begin
			if (failures == 0 && checks_done > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask : finish_test

	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 60000)
		begin
			failures++;
			finish_test();
		end
	end

	task automatic check(input string what, input logic [7:0] e,
		input logic [7:0] g);
		begin
			checks_done++;
			if (g !== e)
			begin
				failures++;
				$display("unexpected %s: expected %h, seen %h", what, e, g);
			end
		end
	endtask : check

	task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
		begin
			@(posedge sys_clk);
			bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
			@(posedge sys_clk);
			bus_req.wr <= 1'b0;
		end
	endtask : bus_wr

	task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
		begin
			@(posedge sys_clk);
			bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
			@(posedge sys_clk);
			bus_req.rd <= 1'b0;
			#1;
			d = rdata_reg;
		end
	endtask : bus_rd

	function automatic logic [7:0] with_parity(input logic [5:0] f);
		logic p0;
		logic p1;
		begin
			p0 = f[0] ^ f[1] ^ f[2] ^ f[4];
			p1 = ~(f[1] ^ f[3] ^ f[4] ^ f[5]);
			return {p1, p0, f};
		end
	endfunction : with_parity

	task automatic header_case(input logic [7:0] idv, input logic mute);
		logic [7:0] d;
		logic [7:0] r;
		begin
			r = 8'($urandom);
			master.send_header(LHR_SYNC_BYTE, idv);
			repeat (4) @(posedge sys_clk);
			check("irq", 8'h01, 8'(irq));
			bus_rd(LHR_OFF_CTRL6, d);
			check("hdr", 8'h01, 8'(d[LHR_C6_HDF]));
			check("pe", 8'(idv !== with_parity(idv[5:0])),
				8'(d[LHR_C6_PE]));
			bus_rd(LHR_OFF_DATA, d);
			check("id", idv, d);
			bus_rd(LHR_OFF_CTRL2, d);
			check("mute", 8'h00, 8'(d[LHR_C2_RWU]));
			bus_wr(LHR_OFF_CTRL6, C6_RUN);
			@(posedge sys_clk);
			check("irq clr", 8'h00, 8'(irq));
			master.send_char(r, 1'b1);
			repeat (4) @(posedge sys_clk);
			bus_rd(LHR_OFF_STATUS, d);
			check("receive_not_empty_flag", 8'h01, 8'(d[LHR_SR_RECEIVE_NOT_EMPTY_FLAG]));
			bus_rd(LHR_OFF_DATA, d);
			check("resp", r, d);
			bus_rd(LHR_OFF_STATUS, d);
			check("receive_not_empty_flag clr", 8'h00, 8'(d[LHR_SR_RECEIVE_NOT_EMPTY_FLAG]));
		end
	endtask : header_case

	// Kind 0 bad sync, 1 framing error in identifier, 2 time-out
	task automatic error_case(input int kind, input logic mute);
		logic [7:0] d;
		begin
			master.hold_bits(1'b0, 13);
			master.hold_bits(1'b1, 1);
			master.send_char(kind == 0 ? 8'h54 : LHR_SYNC_BYTE, 1'b1);
			if (kind == 1)
				master.send_char(with_parity(6'($urandom)), 1'b0);
			if (kind == 2)
			begin
				master.hold_bits(1'b1, 40);
				bus_rd(LHR_OFF_STATUS, d);
				check("he early", 8'h00, 8'(d[LHR_SR_HE]));
				master.hold_bits(1'b1, 12);
			end
			repeat (4) @(posedge sys_clk);
			check("irq he", 8'h01, 8'(irq));
			bus_rd(LHR_OFF_STATUS, d);
			check("he", 8'h01, 8'(d[LHR_SR_HE]));
			bus_rd(LHR_OFF_CTRL6, d);
			check("no hdr", 8'h00, 8'(d[LHR_C6_HDF]));
			bus_rd(LHR_OFF_CTRL2, d);
			check("mute kept", 8'(mute), 8'(d[LHR_C2_RWU]));
			bus_rd(LHR_OFF_STATUS, d);
			bus_rd(LHR_OFF_DATA, d);
			bus_rd(LHR_OFF_STATUS, d);
			check("he clr", 8'h00, 8'(d[LHR_SR_HE]));
			bus_wr(LHR_OFF_CTRL6, C6_RUN);
		end
	endtask : error_case

	initial
	begin
		logic [7:0] d;
		void'($urandom(5));
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		bus_wr(LHR_OFF_BAUD_LO, 8'h10);
		bus_wr(LHR_OFF_BAUD_HI, 8'h00);
		bus_wr(LHR_OFF_CTRL2, C2_RUN);
		bus_wr(LHR_OFF_CTRL6, C6_RUN);
		bus_wr(LHR_OFF_CTRL3, 8'h40);
		header_case(with_parity(6'h00), 1'b0);
		header_case(with_parity(6'h3f), 1'b0);
		for (int i = 0; i < 6; i++)
			header_case({2'($urandom), 6'h00} ^ with_parity(6'($urandom)),
				1'b0);
		for (int m = 0; m < 2; m++)
			for (int k = 0; k < 3; k++)
			begin
				bus_wr(LHR_OFF_CTRL2, C2_RUN | {6'h00, 1'(m), 1'b0});
				error_case(k, 1'(m));
			end
		// Mute: a broken and a clean data character must both vanish
		// Never all zeros, which with a low stop bit would be a break
		master.send_char(8'($urandom) | 8'h01, 1'b0);
		master.send_char(8'($urandom), 1'b1);
		repeat (4) @(posedge sys_clk);
		bus_rd(LHR_OFF_STATUS, d);
		check("fe mute", 8'h00, 8'(d[LHR_SR_FE]));
		check("receive_not_empty_flag mute", 8'h00, 8'(d[LHR_SR_RECEIVE_NOT_EMPTY_FLAG]));
		header_case(with_parity(6'($urandom)) ^ 8'h80, 1'b1);
		finish_test();
	end
endmodule : lin_header_and_response_logic_test
